/* motion_ctrl.sv */
// stepper motion-state controller with apb register access
// assumes commands arrive as apb writes; analog faults arrive on pins
//
// The implementer's own choices: the APB interface to the registers and the register addresses.

// Overview of operation
// - leaving sleep reinitialises all controller state like power-on reset, except the two_leg_move parameter copy
// - after reset controller sits in idle_after_poweron before motion
// - two_leg_move uses its own parameter copy taken at sequence start
// - second leg forces ramp_profile_sel to one; stored value later
// - complete status during two_leg_move reports ram top and floor speed
// - sleep request set by timeout or sleep command, cleared by next command
// - shutdown held until thermal, hard fault, pump fail and undervoltage flags all clear
// - fault flags clear only on status read with conditions normal, except lost step, which any status read clears
// - parameters loaded in two_leg_move reach the speed outputs when two_leg_move ends; ram_shape applies at once
// - sleep while moving retargets to secure position if valid, else goes via ramped halt, stopped, then sleep
// - stopped with sleep request: sleep or move to secure position
// - secure_pos_valid is one unless secure position is 0x400
// - stop marker set leaving ramped or abrupt halt, cleared first edge in stopped
// - id assignment decoded except in sleep, no state change
// - stopped with position mismatch moves, lowest priority transition
// - lost step still allows moves; only status read clears it
// - doze_allowed zero blocks stopped to sleep
// - undervoltage over 15 s leads to undervolt halt or abrupt halt
module motion_ctrl
	import motion_pkg::*;
#(
	parameter longint unsigned UV_CYC = UV_HOLD_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bus_timeout,
	input  wire logic        undervolt_pin,
	input  wire logic        thermal_pin,
	input  wire logic        coil_defect_pin,
	input  wire logic        pump_fail_pin,
	input  wire logic        motion_done,
	input  wire logic        step_tick,
	output logic             bridge_enable,
	output logic             ramp_profile_out,
	output logic [SPD_W-1:0] top_speed_out,
	output logic [SPD_W-1:0] floor_speed_out,
	output logic             id_assign_pulse
);
	logic uv_s;
	logic tsd_s;
	logic coil_s;
	logic pump_s;
	logic uv_long;

	sync3 u_uv   (.pclk(pclk), .presetn(presetn), .din(undervolt_pin),   .dout(uv_s));
	sync3 u_tsd  (.pclk(pclk), .presetn(presetn), .din(thermal_pin),     .dout(tsd_s));
	sync3 u_coil (.pclk(pclk), .presetn(presetn), .din(coil_defect_pin), .dout(coil_s));
	sync3 u_pump (.pclk(pclk), .presetn(presetn), .din(pump_fail_pin),   .dout(pump_s));
	hold_timer #(.HOLD_CYC(UV_CYC)) u_uvt (.pclk(pclk), .presetn(presetn), .level(uv_s), .expired(uv_long));

	state_t            state;
	logic              wake_rst;
	logic [POS_W-1:0]  act_pos;
	logic [POS_W-1:0]  tag_pos;
	logic [SEC_W-1:0]  sec_pos;
	logic [SPD_W-1:0]  ram_top;
	logic [SPD_W-1:0]  ram_floor;
	logic [7:0]        ram_ramp;
	logic              ram_shape;
	logic              doze_allowed;
	logic [SPD_W-1:0]  seq_top;
	logic [SPD_W-1:0]  seq_floor;
	logic [POS_W-1:0]  seq_pos2;
	logic              second_leg;
	logic              sleep_req;
	logic              stop_marker;
	logic              lost_step_flag;
	logic              thermal_off_flag;
	logic              hard_fault_flag;
	logic              pump_fail_flag;
	logic              uv_flag;
	logic              status_seen;

	wire apb_wr  = psel && penable && pwrite;
	wire apb_rd  = psel && penable && !pwrite;
	wire cmd_wr  = apb_wr && paddr == ADDR_CMD;
	wire cmd_t cmd = cmd_wr ? cmd_t'(pwdata[3:0]) : CMD_NONE;
	wire status_rd = cmd == CMD_READ_SHORT || cmd == CMD_READ_FULL;
	wire secure_pos_valid = sec_valid(sec_pos);
	wire [POS_W-1:0] sec_ext = {{(POS_W-SEC_W){sec_pos[SEC_W-1]}}, sec_pos};
	wire conds_ok = !tsd_s && !uv_s && !coil_s && !pump_s;
	wire is_moving = state == ST_MOVING || state == ST_TWO_LEG;
	wire mapped = paddr[1:0] == 2'b00 && paddr <= ADDR_CTRL;

	// leaving sleep behaves as power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wake_rst <= 1'b0;
		else
			wake_rst <= state == ST_SLEEP && cmd_wr;
	end

	// apb slave: zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= '0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
				ADDR_TARGET: prdata <= {16'h0000, tag_pos};
				ADDR_SECPOS: prdata <= {21'h0, sec_pos};
				ADDR_PARAMS: prdata <= {15'h0, ram_shape, ram_ramp, ram_floor, ram_top};
				ADDR_STATE:  prdata <= {28'h0000000, state};
				ADDR_FLAGS:  prdata <= {24'h000000, secure_pos_valid, uv_flag, pump_fail_flag,
					hard_fault_flag, thermal_off_flag, lost_step_flag, stop_marker, sleep_req};
				ADDR_ACTPOS: prdata <= {16'h0000, act_pos};
				ADDR_SPEEDS: prdata <= {24'h000000, ram_floor, ram_top};
				ADDR_CTRL:   prdata <= {31'h0, doze_allowed};
				default:     prdata <= '0;
				endcase
			end
		end
	end

	// ram parameters and secure position
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_pos      <= RST_SECPOS;
			ram_top      <= RST_TOP;
			ram_floor    <= RST_FLOOR;
			ram_ramp     <= RST_RAMP;
			ram_shape    <= 1'b0;
			doze_allowed <= 1'b0;
		end else if (wake_rst) begin
			sec_pos      <= RST_SECPOS;
			ram_top      <= RST_TOP;
			ram_floor    <= RST_FLOOR;
			ram_ramp     <= RST_RAMP;
			ram_shape    <= 1'b0;
			doze_allowed <= 1'b0;
		end else if (apb_wr && state != ST_SLEEP) begin
			if (paddr == ADDR_SECPOS)
				sec_pos <= pwdata[SEC_W-1:0];
			if (paddr == ADDR_PARAMS) begin
				ram_top   <= pwdata[3:0];
				ram_floor <= pwdata[7:4];
				ram_ramp  <= pwdata[15:8];
				ram_shape <= pwdata[16];
			end
			if (paddr == ADDR_CTRL)
				doze_allowed <= pwdata[0];
		end
	end

	// two_leg_move private parameter set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_top   <= RST_TOP;
			seq_floor <= RST_FLOOR;
			seq_pos2  <= RST_POS;
		end else if (cmd == CMD_TWO_LEG && state == ST_STOPPED) begin
			seq_top   <= pwdata[15:12] != 4'h0 ? pwdata[15:12] : ram_top;
			seq_floor <= pwdata[11:8] != 4'h0 ? pwdata[11:8] : ram_floor;
			seq_pos2  <= pwdata[31:16];
		end
	end

	// outputs to the ramp generator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_speed_out    <= RST_TOP;
			floor_speed_out  <= RST_FLOOR;
			ramp_profile_out <= 1'b0;
			bridge_enable    <= 1'b0;
		end else begin
			top_speed_out    <= state == ST_TWO_LEG ? seq_top : ram_top;
			floor_speed_out  <= state == ST_TWO_LEG ? seq_floor : ram_floor;
			ramp_profile_out <= (state == ST_TWO_LEG && second_leg) ? 1'b1 : ram_shape;
			bridge_enable    <= state != ST_SHUTDOWN && state != ST_SLEEP && state != ST_IDLE_POWERON;
		end
	end

	// id assignment decoded except in sleep, no state effect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			id_assign_pulse <= 1'b0;
		else
			id_assign_pulse <= cmd == CMD_ASSIGN_ID && state != ST_SLEEP;
	end

	// sleep request flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sleep_req <= 1'b0;
		else if (wake_rst)
			sleep_req <= 1'b0;
		else if (bus_timeout || cmd == CMD_SLEEP)
			sleep_req <= 1'b1;
		else if (cmd_wr)
			sleep_req <= 1'b0;
	end

	// fault flags: set wins, clear only via status read, with normal conditions needed for all but lost step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thermal_off_flag <= 1'b0;
			hard_fault_flag  <= 1'b0;
			pump_fail_flag   <= 1'b0;
			uv_flag          <= 1'b0;
			lost_step_flag   <= 1'b0;
			status_seen      <= 1'b0;
		end else if (wake_rst) begin
			thermal_off_flag <= 1'b0;
			hard_fault_flag  <= 1'b0;
			pump_fail_flag   <= 1'b0;
			uv_flag          <= 1'b0;
			lost_step_flag   <= 1'b0;
			status_seen      <= 1'b0;
		end else begin
			status_seen      <= status_rd;
			thermal_off_flag <= tsd_s || (thermal_off_flag && !(status_rd && conds_ok));
			hard_fault_flag  <= coil_s || (hard_fault_flag && !(status_rd && conds_ok));
			pump_fail_flag   <= pump_s || (pump_fail_flag && !(status_rd && conds_ok));
			uv_flag          <= uv_long || (uv_flag && !(status_rd && conds_ok));
			lost_step_flag   <= ((coil_s || pump_s) && (is_moving || state == ST_RAMPED_HALT))
				|| (lost_step_flag && !status_rd);
		end
	end

	// actual position follows the step generator toward target
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			act_pos <= RST_POS;
		else if (wake_rst || cmd == CMD_RESET_POS)
			act_pos <= RST_POS;
		else if (step_tick && act_pos != tag_pos && state != ST_SHUTDOWN)
			act_pos <= $signed(tag_pos) > $signed(act_pos) ? act_pos + 16'h0001 : act_pos - 16'h0001;
	end

	// main state machine with target position
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state       <= ST_IDLE_POWERON;
			tag_pos     <= RST_POS;
			stop_marker <= 1'b0;
			second_leg  <= 1'b0;
		end else if (wake_rst) begin
			state       <= ST_IDLE_POWERON;
			tag_pos     <= RST_POS;
			stop_marker <= 1'b0;
			second_leg  <= 1'b0;
		end else begin
			case (state)
			ST_IDLE_POWERON: begin
				if (sleep_req && cmd == CMD_NONE)
					state <= ST_SLEEP;
				else if (cmd == CMD_MOVE || cmd == CMD_MOVE_BRIEF) begin
					tag_pos <= pwdata[31:16];
					state   <= ST_MOVING;
				end else if (cmd == CMD_GO_SAFE && secure_pos_valid) begin
					tag_pos <= sec_ext;
					state   <= ST_MOVING;
				end else if (cmd == CMD_RESET_POS)
					tag_pos <= RST_POS;
			end
			ST_STOPPED: begin
				stop_marker <= 1'b0;
				second_leg  <= 1'b0;
				if (tsd_s || thermal_off_flag || coil_s || hard_fault_flag)
					state <= ST_SHUTDOWN;
				else if (uv_long)
					state <= ST_UV_HALT;
				else if (sleep_req && cmd == CMD_NONE) begin
					if (!secure_pos_valid || act_pos == sec_ext || stop_marker) begin
						if (doze_allowed)
							state <= ST_SLEEP;
					end else begin
						tag_pos <= sec_ext;
						state   <= ST_MOVING;
					end
				end else if (cmd == CMD_MOVE || cmd == CMD_MOVE_BRIEF) begin
					tag_pos <= pwdata[31:16];
					state   <= ST_MOVING;
				end else if (cmd == CMD_GO_SAFE && secure_pos_valid) begin
					tag_pos <= sec_ext;
					state   <= ST_MOVING;
				end else if (cmd == CMD_TWO_LEG) begin
					tag_pos <= {{(POS_W-8){pwdata[7]}}, pwdata[7:0]};
					state   <= ST_TWO_LEG;
				end else if (cmd == CMD_RESET_POS)
					tag_pos <= RST_POS;
				else if (act_pos != tag_pos)
					state <= ST_MOVING;
			end
			ST_MOVING: begin
				if (coil_s || pump_s) begin
					state <= ST_ABRUPT_HALT;
				end else if (uv_long)
					state <= ST_UV_HALT;
				else if (tsd_s)
					state <= ST_RAMPED_HALT;
				else if (cmd == CMD_HARD_STOP)
					state <= ST_ABRUPT_HALT;
				else if (cmd == CMD_SOFT_STOP)
					state <= ST_RAMPED_HALT;
				else if (sleep_req && cmd == CMD_NONE) begin
					if (secure_pos_valid)
						tag_pos <= sec_ext;
					else
						state <= ST_RAMPED_HALT;
				end else if (cmd == CMD_MOVE || cmd == CMD_MOVE_BRIEF)
					tag_pos <= pwdata[31:16];
				else if (cmd == CMD_GO_SAFE && secure_pos_valid)
					tag_pos <= sec_ext;
				else if (motion_done && act_pos == tag_pos)
					state <= ST_STOPPED;
			end
			ST_TWO_LEG: begin
				if (coil_s || pump_s || uv_long || cmd == CMD_HARD_STOP)
					state <= ST_ABRUPT_HALT;
				else if (tsd_s)
					state <= ST_RAMPED_HALT;
				else if (motion_done && act_pos == tag_pos) begin
					if (second_leg)
						state <= ST_STOPPED;
					else begin
						second_leg <= 1'b1;
						tag_pos    <= seq_pos2;
					end
				end
			end
			ST_RAMPED_HALT: begin
				if (coil_s || pump_s)
					state <= ST_ABRUPT_HALT;
				else if (uv_long)
					state <= ST_UV_HALT;
				else if (motion_done) begin
					tag_pos     <= act_pos;
					stop_marker <= 1'b1;
					state       <= ST_STOPPED;
				end
			end
			ST_ABRUPT_HALT: begin
				if (motion_done) begin
					tag_pos     <= act_pos;
					stop_marker <= 1'b1;
					state       <= ST_STOPPED;
				end
			end
			ST_UV_HALT: begin
				tag_pos <= act_pos;
				if (coil_s)
					state <= ST_SHUTDOWN;
				else if (tsd_s)
					state <= ST_SHUTDOWN;
				else if (!uv_s)
					state <= ST_STOPPED;
			end
			ST_SHUTDOWN: begin
				tag_pos <= act_pos;
				if (!thermal_off_flag && !hard_fault_flag && !uv_flag && !pump_fail_flag)
					state <= ST_STOPPED;
			end
			ST_SLEEP: ;
			default: state <= ST_IDLE_POWERON;
			endcase
		end
	end
endmodule : motion_ctrl

/* motion_pkg.sv */
// motion controller constants, state and command encodings
// assumes a single 100 MHz clock domain
package motion_pkg;
	localparam int unsigned CLK_HZ            = 100_000_000;
	localparam int unsigned UV_HOLD_S         = 15;
	localparam longint unsigned UV_HOLD_CYC   = longint'(UV_HOLD_S) * longint'(CLK_HZ);
	localparam int unsigned POS_W             = 16;
	localparam int unsigned SEC_W             = 11;
	localparam logic [10:0] SEC_POS_NONE      = 11'h400;
	localparam int unsigned SPD_W             = 4;

	// apb map
	localparam logic [7:0] ADDR_CMD           = 8'h00;
	localparam logic [7:0] ADDR_TARGET        = 8'h04;
	localparam logic [7:0] ADDR_SECPOS        = 8'h08;
	localparam logic [7:0] ADDR_PARAMS        = 8'h0C;
	localparam logic [7:0] ADDR_STATE         = 8'h10;
	localparam logic [7:0] ADDR_FLAGS         = 8'h14;
	localparam logic [7:0] ADDR_ACTPOS        = 8'h18;
	localparam logic [7:0] ADDR_SPEEDS        = 8'h1C;
	localparam logic [7:0] ADDR_CTRL          = 8'h20;

	localparam logic [POS_W-1:0] RST_POS      = 16'h0000;
	localparam logic [SEC_W-1:0] RST_SECPOS   = 11'h400;
	localparam logic [SPD_W-1:0] RST_TOP      = 4'h8;
	localparam logic [SPD_W-1:0] RST_FLOOR    = 4'h1;
	localparam logic [7:0] RST_RAMP           = 8'h10;

	typedef enum logic [3:0] {
		CMD_NONE, CMD_MOVE, CMD_MOVE_BRIEF, CMD_GO_SAFE, CMD_TWO_LEG, CMD_SOFT_STOP,
		CMD_HARD_STOP, CMD_SLEEP, CMD_READ_SHORT, CMD_READ_FULL, CMD_LOAD_PARAMS,
		CMD_RESET_POS, CMD_ASSIGN_ID
	} cmd_t;

	typedef enum logic [3:0] {
		ST_IDLE_POWERON, ST_STOPPED, ST_MOVING, ST_TWO_LEG, ST_RAMPED_HALT,
		ST_ABRUPT_HALT, ST_UV_HALT, ST_SHUTDOWN, ST_SLEEP
	} state_t;

	function automatic logic sec_valid(input logic [SEC_W-1:0] p);
		return p != SEC_POS_NONE;
	endfunction
endpackage : motion_pkg

/* sync3.sv */
// three-stage synchroniser, change accepted when stages 2 and 3 agree
// assumes an asynchronous pin input
module sync3
	import motion_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output logic      dout
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dout <= 1'b0;
		else if (s2 == s3)
			dout <= s3;
	end
endmodule : sync3

/* hold_timer.sv */
// counts how long a level stays high, flags once the hold time passes
// assumes a synchronised level input
module hold_timer
	import motion_pkg::*;
#(
	parameter longint unsigned HOLD_CYC = UV_HOLD_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic level,
	output logic      expired
);
	logic [40:0] cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt     <= '0;
			expired <= 1'b0;
		end else if (!level) begin
			cnt     <= '0;
			expired <= 1'b0;
		end else if (cnt >= HOLD_CYC[40:0]) begin
			expired <= 1'b1;
		end else begin
			cnt <= cnt + 41'd1;
		end
	end
endmodule : hold_timer

/* motion_ctrl_properties.sv */
// port-level checks of the motion controller's apb answers and pulses
// assumes binding onto motion_ctrl with one clock and async active-low reset
module motion_ctrl_properties
	import motion_pkg::*;
#(
	parameter longint unsigned UV_CYC = UV_HOLD_CYC
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        coil_defect_pin,
	input wire logic        bridge_enable,
	input wire logic        id_assign_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic access;
	logic bad_addr;
	logic id_wr;
	assign access   = psel && penable && pready;
	assign bad_addr = (paddr > 8'h20) || (paddr[1:0] != 2'h0);
	assign id_wr    = access && pwrite && (paddr == ADDR_CMD) && (pwdata[3:0] == CMD_ASSIGN_ID);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence shut_s;
		coil_defect_pin [*8] ##1 !bridge_enable;
	endsequence
	chk_ready_setup: assert property (setup_s |=> pready && psel && penable) else $error("no ready after setup");
	chk_ready_single: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	chk_err_unmapped: assert property (access && bad_addr |-> pslverr) else $error("unmapped access not refused");
	chk_err_mapped: assert property (access && !bad_addr |-> !pslverr) else $error("mapped access refused");
	chk_err_zero: assert property (access && !pwrite && pslverr |-> prdata == 32'h0) else $error("refused read data");
	chk_id_single: assert property (id_assign_pulse |=> !id_assign_pulse) else $error("id pulse too long");
	chk_id_cause: assert property ($rose(id_assign_pulse) |-> $past(id_wr, 1) || $past(id_wr, 2))
		else $error("id pulse without command");
	chk_shutdown_hold: assert property (shut_s |=> !bridge_enable) else $error("bridge on during coil fault");
endmodule // motion_ctrl_properties

bind motion_ctrl motion_ctrl_properties #(.UV_CYC(UV_CYC)) i_motion_ctrl_properties (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .coil_defect_pin(coil_defect_pin), .bridge_enable(bridge_enable),
	.id_assign_pulse(id_assign_pulse));

/* apb_master.sv */
// bus master model issuing commands and status reads as apb transfers
// assumes a slave that raises pready within the access phase
module apb_master
	import motion_pkg::*;
(
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= we;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// ready, data and error are taken at the edge that ends the access
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // apb_master

/* tb_motion_ctrl.sv */
// self-checking bench: register rows, then motion, fault and sleep cases
// assumes motion_pkg encodings and the apb map of the controller
module tb_motion_ctrl
	import motion_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e; logic err;} row_t;
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	logic             bus_timeout = 1'b0;
	logic             undervolt_pin = 1'b0;
	logic             thermal_pin = 1'b0;
	logic             coil_defect_pin = 1'b0;
	logic             motion_done = 1'b0;
	logic             step_tick = 1'b0;
	logic             psel, penable, pwrite, pready, pslverr;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata;
	logic             bridge_enable, ramp_profile_out, id_assign_pulse;
	logic [SPD_W-1:0] top_speed_out, floor_speed_out;
	int               err_total = 0;
	int               checks_done = 0;
	row_t rows [0:12] = '{
		'{0, ADDR_STATE, 0, 32'hF, 32'h0, 0}, '{0, ADDR_SECPOS, 0, 32'h7FF, 32'h400, 0},
		'{0, ADDR_FLAGS, 0, 32'h80, 32'h0, 0}, '{0, ADDR_SPEEDS, 0, 32'hFF, 32'h18, 0},
		'{0, ADDR_PARAMS, 0, 32'h1FFFF, 32'h1018, 0}, '{0, ADDR_CTRL, 0, 32'h1, 32'h0, 0},
		'{0, 8'h24, 0, 32'hFFFFFFFF, 32'h0, 1}, '{1, 8'h02, 32'h1, 32'h0, 32'h0, 1},
		'{1, ADDR_SECPOS, 32'h5, 32'h0, 32'h0, 0}, '{0, ADDR_FLAGS, 0, 32'h80, 32'h80, 0},
		'{1, ADDR_SECPOS, 32'h400, 32'h0, 32'h0, 0}, '{0, ADDR_FLAGS, 0, 32'h80, 32'h0, 0},
		'{1, ADDR_CTRL, 32'h1, 32'h0, 32'h0, 0}};
	apb_master i_apb_master (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	motion_ctrl #(.UV_CYC(50)) i_motion_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_timeout(bus_timeout), .undervolt_pin(undervolt_pin), .thermal_pin(thermal_pin),
		.coil_defect_pin(coil_defect_pin), .pump_fail_pin(1'b0), .motion_done(motion_done),
		.step_tick(step_tick), .bridge_enable(bridge_enable), .ramp_profile_out(ramp_profile_out),
		.top_speed_out(top_speed_out), .floor_speed_out(floor_speed_out), .id_assign_pulse(id_assign_pulse));
	always #5 pclk = ~pclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		logic er;
		i_apb_master.xfer(1'b0, a, 32'h0, v, er);
		chk(v & m, e);
	endtask
	task automatic cmd(input logic [31:0] d);
		logic [31:0] v;
		logic er;
		i_apb_master.xfer(1'b1, ADDR_CMD, d, v, er);
	endtask
	task automatic st(input state_t s);
		logic [31:0] v;
		logic er;
		repeat (40) begin
			i_apb_master.xfer(1'b0, ADDR_STATE, 32'h0, v, er);
			if (v[3:0] === s) break;
		end
		chk(v, {28'h0, s});
	endtask
	task automatic steps(input int n);
		repeat (n) begin
			@(posedge pclk) step_tick <= 1'b1;
			@(posedge pclk) step_tick <= 1'b0;
		end
		@(posedge pclk) motion_done <= 1'b1;
		@(posedge pclk) motion_done <= 1'b0;
	endtask
	task automatic close_out;
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200us;
		err_total++;
		close_out();
	end
	initial begin
		logic [31:0] v;
		logic er;
		logic seen;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({top_speed_out, floor_speed_out}, 32'h81);
		foreach (rows[i]) begin
			i_apb_master.xfer(rows[i].we, rows[i].a, rows[i].d, v, er);
			chk(v & rows[i].m, rows[i].e);
			chk({31'h0, er}, {31'h0, rows[i].err});
		end
		cmd({16'h0003, 12'h0, CMD_MOVE});
		st(ST_MOVING);
		chk(bridge_enable, 1'b1);
		steps(3);
		st(ST_STOPPED);
		rdm(ADDR_ACTPOS, 32'hFFFF, 32'h3);
		coil_defect_pin <= 1'b1;
		st(ST_SHUTDOWN);
		rdm(ADDR_FLAGS, 32'h10, 32'h10);
		coil_defect_pin <= 1'b0;
		repeat (10) @(posedge pclk);
		st(ST_SHUTDOWN);
		cmd({28'h0, CMD_READ_SHORT});
		st(ST_STOPPED);
		cmd({16'h0006, 12'h0, CMD_MOVE});
		st(ST_MOVING);
		coil_defect_pin <= 1'b1;
		st(ST_ABRUPT_HALT);
		rdm(ADDR_FLAGS, 32'h14, 32'h14);
		coil_defect_pin <= 1'b0;
		steps(0);
		repeat (10) @(posedge pclk);
		cmd({28'h0, CMD_READ_SHORT});
		rdm(ADDR_FLAGS, 32'h14, 32'h0);
		st(ST_STOPPED);
		cmd({28'h0, CMD_ASSIGN_ID});
		seen = 1'b0;
		repeat (4) @(negedge pclk) seen |= id_assign_pulse;
		chk(seen, 1'b1);
		st(ST_STOPPED);
		cmd({16'h0002, 4'h3, 4'h0, 8'h04});
		st(ST_TWO_LEG);
		chk({top_speed_out, floor_speed_out}, 32'h31);
		rdm(ADDR_SPEEDS, 32'hFF, 32'h18);
		steps(1);
		repeat (3) @(posedge pclk);
		chk(ramp_profile_out, 1'b1);
		steps(2);
		st(ST_STOPPED);
		chk(ramp_profile_out, 1'b0);
		cmd({16'h0009, 12'h0, CMD_MOVE});
		st(ST_MOVING);
		cmd({28'h0, CMD_SLEEP});
		rdm(ADDR_FLAGS, 32'h1, 32'h1);
		st(ST_RAMPED_HALT);
		steps(0);
		st(ST_SLEEP);
		cmd({28'h0, CMD_NONE});
		st(ST_IDLE_POWERON);
		rdm(ADDR_CTRL, 32'h1, 32'h0);
		cmd({16'h0002, 12'h0, CMD_MOVE});
		st(ST_MOVING);
		steps(2);
		st(ST_STOPPED);
		@(posedge pclk) bus_timeout <= 1'b1;
		@(posedge pclk) bus_timeout <= 1'b0;
		rdm(ADDR_FLAGS, 32'h1, 32'h1);
		repeat (20) @(posedge pclk);
		st(ST_STOPPED);
		cmd({28'h0, CMD_READ_SHORT});
		rdm(ADDR_FLAGS, 32'h1, 32'h0);
		cmd({16'h0005, 12'h0, CMD_MOVE});
		st(ST_MOVING);
		thermal_pin <= 1'b1;
		st(ST_RAMPED_HALT);
		rdm(ADDR_FLAGS, 32'h8, 32'h8);
		thermal_pin <= 1'b0;
		steps(0);
		st(ST_SHUTDOWN);
		cmd({28'h0, CMD_READ_SHORT});
		st(ST_STOPPED);
		rdm(ADDR_FLAGS, 32'h8, 32'h0);
		undervolt_pin <= 1'b1;
		repeat (80) @(posedge pclk);
		st(ST_UV_HALT);
		close_out();
	end
endmodule // tb_motion_ctrl
